// file: verilog/stsc_top.sv
/*
 * Status tail and extended control bank: master-active, reset flags,
 * two-wire pin routing, pin 2/3 data and interrupt detect.
 * Assumes an Avalon-MM master, a power-on reset separate from reset_i,
 * and store values stable when reset_i releases.
 */
// Decided for this implementation: the Avalon-MM register port.
`default_nettype none
module stsc_top
    import stsc_pkg::*;
(
    // Clock, resets
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        por_i,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output var  logic [31:0] avs_readdata_o,
    output var  logic        avs_waitrequest_o,
    // Device control side
    input  wire logic        bus_master_disable_i,
    input  wire logic        master_pending_i,
    input  wire logic        master_want_i,
    output var  logic        master_grant_o,
    input  wire logic        device_reset_request_i,
    input  wire logic        reset_finished_i,
    // Nonvolatile store values
    input  wire logic [1:0]  nv_signature_i,
    input  wire logic        nv_gating_i,
    input  wire logic        nv_two_wire_i,
    input  wire logic        nv_pin2_value_i,
    input  wire logic        nv_pin3_value_i,
    input  wire logic        nv_pin2_dir_i,
    input  wire logic        nv_pin3_dir_i,
    // Two-wire engine
    input  wire logic        tw_clk_oe_n_i,
    input  wire logic        tw_data_oe_n_i,
    output var  logic        tw_data_in_o,
    // Pins 0, 2, 3
    input  wire logic        sw_pin_0_i,
    input  wire logic        sw_pin_2_i,
    input  wire logic        sw_pin_3_i,
    output var  logic        sw_pin_0_o,
    output var  logic        sw_pin_0_oe_n_o,
    output var  logic        sw_pin_2_o,
    output var  logic        sw_pin_2_oe_n_o,
    output var  logic        sw_pin_3_o,
    output var  logic        sw_pin_3_oe_n_o,
    // Input event detect
    output var  logic        general_input_event_o
);
    typedef struct packed {
        logic        master_active;
        logic        grant;
        logic        dev_rst_flag;
        logic        rst_done;
        logic        gating;
        logic        two_wire_en;
        logic        p2_irq_en;
        logic        p3_irq_en;
        logic        p2_value;
        logic        p3_value;
        logic        p2_dir;
        logic        p3_dir;
        logic        p2_last;
        logic        p3_last;
        logic        gpi_evt;
        logic        ack;
        logic [31:0] rdata;
        logic        p0_o;
        logic        p0_oe_n;
        logic        p2_o;
        logic        p2_oe_n;
        logic        p3_o;
        logic        p3_oe_n;
        logic        tw_in;
        logic        rst_seen;
    } stsc_state_type;

    stsc_state_type st;
    stsc_state_type next_st;
    logic [2:0] pins_s;
    logic       nv_ok;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic       wr_stat;
    logic       wr_ctrl;

    // Pin levels into clock domain
    stsc_sync #(.W(3)) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i ({sw_pin_3_i, sw_pin_2_i, sw_pin_0_i}),
        .sync_o  (pins_s)
    );

    assign nv_ok = (nv_signature_i == STSC_SIG_VALID);

    // Read images of both registers
    always_comb begin
        status_word = 32'h0000_0000;                  // 30:22 stay zero
        status_word[STSC_BIT_MASTER_ACT] = st.master_active;
        status_word[STSC_BIT_DEV_RST]    = st.dev_rst_flag;
        status_word[STSC_BIT_RST_DONE]   = st.rst_done;
        status_word[STSC_BIT_GATING]     = st.gating;
        ctrl_word = 32'h0000_0000;
        ctrl_word[STSC_BIT_TWO_WIRE] = st.two_wire_en;
        ctrl_word[STSC_BIT_P2_IRQ]   = st.p2_irq_en;
        ctrl_word[STSC_BIT_P3_IRQ]   = st.p3_irq_en;
        // Inputs read live level, outputs the stored bit
        ctrl_word[STSC_BIT_P2_DATA]  = st.p2_dir ? st.p2_value : pins_s[1];
        ctrl_word[STSC_BIT_P3_DATA]  = st.p3_dir ? st.p3_value : pins_s[2];
        ctrl_word[STSC_BIT_P2_DIR]   = st.p2_dir;
        ctrl_word[STSC_BIT_P3_DIR]   = st.p3_dir;
    end

    // Writes take effect on the accepting edge only, the one showing waitrequest low,
    // so a master that drops its request before that edge commits nothing
    assign wr_stat = avs_write_i && st.ack && avs_address_i == STSC_OFS_STATUS;
    assign wr_ctrl = avs_write_i && st.ack && avs_address_i == STSC_OFS_EXT_CTRL;

    // Next-state logic
    always_comb begin
        next_st = st;
        // One wait cycle, then acknowledge
        next_st.ack = (avs_read_i || avs_write_i) && !st.ack;
        if (avs_read_i && !st.ack) begin
            case (avs_address_i)
                STSC_OFS_STATUS:   next_st.rdata = status_word;
                STSC_OFS_EXT_CTRL: next_st.rdata = ctrl_word;
                default:           next_st.rdata = STSC_DEAD_READ;
            endcase
        end
        // Quiescence tracking
        next_st.master_active = !(bus_master_disable_i && !master_pending_i);
        // Gate new requests while quiesced
        next_st.grant = master_want_i &&
                        !(bus_master_disable_i && !st.master_active);
        // W1C, the set wins over the clear
        if (wr_stat && avs_byteenable_i[2] && avs_writedata_i[STSC_BIT_DEV_RST])
            next_st.dev_rst_flag = 1'b0;
        if (device_reset_request_i)
            next_st.dev_rst_flag = 1'b1;
        // Reset complete; cleared while a new device reset runs
        if (device_reset_request_i)
            next_st.rst_done = 1'b0;
        if (reset_finished_i)
            next_st.rst_done = 1'b1;
        // Store values caught once after reset release
        if (!st.rst_seen) begin
            next_st.rst_seen    = 1'b1;
            next_st.gating      = nv_ok ? nv_gating_i : STSC_RST_DEFAULT;
            next_st.two_wire_en = nv_ok ? nv_two_wire_i : STSC_RST_DEFAULT;
            next_st.p2_value    = nv_ok ? nv_pin2_value_i : STSC_RST_DEFAULT;
            next_st.p3_value    = nv_ok ? nv_pin3_value_i : STSC_RST_DEFAULT;
        end
        if (wr_ctrl && avs_byteenable_i[0]) begin
            next_st.two_wire_en = avs_writedata_i[STSC_BIT_TWO_WIRE];
            next_st.p2_irq_en   = avs_writedata_i[STSC_BIT_P2_IRQ];
            next_st.p3_irq_en   = avs_writedata_i[STSC_BIT_P3_IRQ];
            next_st.p2_value    = avs_writedata_i[STSC_BIT_P2_DATA];
            next_st.p3_value    = avs_writedata_i[STSC_BIT_P3_DATA];
        end
        // Direction bits only by write here; por handled in the ff
        if (wr_ctrl && avs_byteenable_i[1]) begin
            next_st.p2_dir = avs_writedata_i[STSC_BIT_P2_DIR];
            next_st.p3_dir = avs_writedata_i[STSC_BIT_P3_DIR];
        end
        // Edge detect on enabled input pins
        next_st.p2_last = pins_s[1];
        next_st.p3_last = pins_s[2];
        next_st.gpi_evt =
            (!st.p2_dir && st.p2_irq_en && !st.two_wire_en && pins_s[1] != st.p2_last) ||
            (!st.p3_dir && st.p3_irq_en && pins_s[2] != st.p3_last);
        // Pin drivers; two-wire mode is open drain
        if (st.two_wire_en) begin
            next_st.p0_o    = 1'b0;
            next_st.p0_oe_n = tw_clk_oe_n_i;
            next_st.p2_o    = 1'b0;
            next_st.p2_oe_n = tw_data_oe_n_i;
        end else begin
            next_st.p0_o    = 1'b0;
            next_st.p0_oe_n = 1'b1;
            next_st.p2_o    = st.p2_value;
            next_st.p2_oe_n = !st.p2_dir;
        end
        next_st.p3_o    = st.p3_value;
        next_st.p3_oe_n = !st.p3_dir;
        next_st.tw_in   = pins_s[1];
    end

    // State register; direction survives reset_i, only power-on resets it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st               <= '0;
            st.master_active <= STSC_RST_MASTER_ACT;
            st.dev_rst_flag  <= STSC_RST_DEV_RST;
            st.rst_done      <= STSC_RST_RST_DONE;
            st.p0_oe_n       <= 1'b1;
            st.p2_oe_n       <= 1'b1;
            st.p3_oe_n       <= 1'b1;
            // Software reset leaves directions alone
            st.p2_dir        <= st.p2_dir;
            st.p3_dir        <= st.p3_dir;
            // Power-on takes the store's directions when its signature holds
            if (por_i) begin
                st.p2_dir <= nv_ok ? nv_pin2_dir_i : STSC_RST_DEFAULT;
                st.p3_dir <= nv_ok ? nv_pin3_dir_i : STSC_RST_DEFAULT;
            end
        end else if (por_i) begin
            st.p2_dir <= nv_ok ? nv_pin2_dir_i : STSC_RST_DEFAULT;
            st.p3_dir <= nv_ok ? nv_pin3_dir_i : STSC_RST_DEFAULT;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata_o        = st.rdata;
    assign avs_waitrequest_o     = !st.ack;
    assign master_grant_o        = st.grant;
    assign tw_data_in_o          = st.tw_in;
    assign sw_pin_0_o            = st.p0_o;
    assign sw_pin_0_oe_n_o       = st.p0_oe_n;
    assign sw_pin_2_o            = st.p2_o;
    assign sw_pin_2_oe_n_o       = st.p2_oe_n;
    assign sw_pin_3_o            = st.p3_o;
    assign sw_pin_3_oe_n_o       = st.p3_oe_n;
    assign general_input_event_o = st.gpi_evt;

    // Checks
    property p_quiesce;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (bus_master_disable_i && !master_pending_i) |=> !st.master_active;
    endproperty
    a_quiesce: assert property (p_quiesce) else $error("master flag not cleared");
    property p_no_grant;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (bus_master_disable_i && !st.master_active) |=> !st.grant;
    endproperty
    a_no_grant: assert property (p_no_grant) else $error("grant while quiesced");
    property p_dev_set;
        @(posedge clk_i) disable iff (reset_i || por_i)
        device_reset_request_i |=> st.dev_rst_flag;
    endproperty
    a_dev_set: assert property (p_dev_set) else $error("device reset flag missed");
    property p_dev_hold;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (st.dev_rst_flag && !wr_stat) |=> st.dev_rst_flag;
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("flag lost without write");
    property p_done;
        @(posedge clk_i) disable iff (reset_i || por_i)
        reset_finished_i |=> st.rst_done;
    endproperty
    a_done: assert property (p_done) else $error("reset done not set");
    // Check the bus word itself, not the image that builds it
    property p_rsvd;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (!avs_waitrequest_o && avs_address_i == STSC_OFS_STATUS) |->
            avs_readdata_o[30:22] == 9'h000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
    property p_drive3;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (st.p3_dir && $stable(st.p3_dir)) |=> (!sw_pin_3_oe_n_o && sw_pin_3_o == $past(st.p3_value));
    endproperty
    a_drive3: assert property (p_drive3) else $error("pin 3 not driven");
    property p_tw;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (st.two_wire_en && st.rst_seen) |=> (sw_pin_0_oe_n_o == $past(tw_clk_oe_n_i));
    endproperty
    a_tw: assert property (p_tw) else $error("pin 0 not on two-wire");
    // Live read lags the pin by the two sync stages; skipped while they refill
    property p_live;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (!st.p2_dir && !$past(reset_i) && !$past(reset_i, 2)) |->
            ctrl_word[STSC_BIT_P2_DATA] == $past(sw_pin_2_i, 2);
    endproperty
    a_live: assert property (p_live) else $error("input read not live");
    // A qualified edge on an enabled input always raises the event
    property p_evt2;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (!st.p2_dir && st.p2_irq_en && !st.two_wire_en && pins_s[1] != st.p2_last)
            |=> general_input_event_o;
    endproperty
    a_evt2: assert property (p_evt2) else $error("pin 2 edge not reported");
    property p_evt3;
        @(posedge clk_i) disable iff (reset_i || por_i)
        (!st.p3_dir && st.p3_irq_en && pins_s[2] != st.p3_last) |=> general_input_event_o;
    endproperty
    a_evt3: assert property (p_evt3) else $error("pin 3 edge not reported");
    // Directions survive a software-only reset
    property p_dir_keep;
        @(posedge clk_i) (reset_i && !por_i) |=>
            (st.p2_dir == $past(st.p2_dir) && st.p3_dir == $past(st.p3_dir));
    endproperty
    a_dir_keep: assert property (p_dir_keep) else $error("direction lost");
    c_quiesce:  cover property (@(posedge clk_i) !st.master_active);
    c_w1c:      cover property (@(posedge clk_i) st.dev_rst_flag ##1 !st.dev_rst_flag);
    c_gpi:      cover property (@(posedge clk_i) general_input_event_o);
    c_dir_hold: cover property (@(posedge clk_i) reset_i && !por_i && st.p3_dir);
    c_tw_drive: cover property (@(posedge clk_i) st.two_wire_en && !sw_pin_0_oe_n_o);
endmodule
`default_nettype wire

// file: verilog/stsc_pkg.sv
/*
 * Constants for the status tail and pin control register bank.
 * Assumes a 32-bit Avalon-MM slave, word addressed by byte offset.
 */
// How it works
// - Master-active flag clears when master disable set and nothing pending.
// - With disable set and flag clear, no new master requests are issued.
// - Device reset request sets the device reset flag, bit 20.
// - Device reset flag clears only on a written one.
// - Reset-complete flag, bit 21, sets when a reset finishes.
// - Clock gating capable bit 31 comes from the nonvolatile store.
// - Loadable bits use store values only when signature equals 01b.
// - Two-wire enable bit 1 routes pins 0 and 2 to two-wire engine.
// - Pin 2 as input with bit 2 set and two-wire off feeds input event detection.
// - Pin 3 as input with bit 3 set feeds input event detection.
// - Input pins return their live level on data bit reads.
// - Pin data reset values come from store when valid, else zero.
// - Status bits 30:22 read as zero.
// - Direction bit one means output; only power-on or writes change it.
`default_nettype none
package stsc_pkg;
    localparam logic [7:0] STSC_OFS_EXT_CTRL = 8'h18;
    localparam logic [7:0] STSC_OFS_STATUS   = 8'h08;
    localparam int STSC_BIT_MASTER_ACT = 19;
    localparam int STSC_BIT_DEV_RST    = 20;
    localparam int STSC_BIT_RST_DONE   = 21;
    localparam int STSC_BIT_GATING     = 31;
    localparam int STSC_BIT_TWO_WIRE   = 1;
    localparam int STSC_BIT_P2_IRQ     = 2;
    localparam int STSC_BIT_P3_IRQ     = 3;
    localparam int STSC_BIT_P2_DATA    = 6;
    localparam int STSC_BIT_P3_DATA    = 7;
    localparam int STSC_BIT_P2_DIR     = 10;
    localparam int STSC_BIT_P3_DIR     = 11;
    localparam logic [1:0] STSC_SIG_VALID = 2'h1;
    localparam logic STSC_RST_MASTER_ACT = 1'h1;
    localparam logic STSC_RST_DEV_RST    = 1'h0;
    localparam logic STSC_RST_RST_DONE   = 1'h1;
    localparam logic STSC_RST_DEFAULT    = 1'h0;
    localparam logic [31:0] STSC_DEAD_READ = 32'h0000_0000;
endpackage
`default_nettype wire

// file: verilog/stsc_sync.sv
/*
 * Two-flop synchronizer, one per bit, generate loop.
 * Assumes inputs are asynchronous to clk_i.
 */
`default_nettype none
module stsc_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // Data
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);
    logic [W-1:0] meta;
    genvar g;
    // First stage read only by the second
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    meta[g]   <= 1'b0;
                    sync_o[g] <= 1'b0;
                end else begin
                    meta[g]   <= async_i[g];
                    sync_o[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: bench/stsc_pins.sv
/*
 * Far-side model of software pins 0, 2 and 3: device, outside driver, pull-up.
 * Assumes the bench sets the outside drive; released lines pull high.
 */
`default_nettype none
module stsc_pins (
    // Device side, index 0 = pin 0, 1 = pin 2, 2 = pin 3
    input  wire logic [2:0] dev_o_i,
    input  wire logic [2:0] dev_oe_n_i,
    // Outside driver
    input  wire logic [2:0] ext_en_i,
    input  wire logic [2:0] ext_val_i,
    // Resolved wire levels
    output var  logic [2:0] level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Wired-AND over a pull-up, so a released line never keeps a stale value
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            level_o[k] = (dev_oe_n_i[k] | dev_o_i[k]) & (!ext_en_i[k] | ext_val_i[k]);
        end
    end
endmodule
`default_nettype wire

// file: bench/stsc_top_test.sv
/*
 * Self-checking bench for the status tail and pin control bank.
 * Assumes the pin model above and the one-cycle bus answer of the design.
 */
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR %0t: got %h want %h", $time, got, exp); end end
module stsc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 0, reset_i = 1, por_i = 1;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 0, avs_write_i = 0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic        dis = 0, pend = 1, want = 0, dreq = 0, dfin = 0;
    logic [1:0]  sig = 2'h1;
    logic        tw_c = 1, tw_d = 1, gat = 1;
    logic [2:0]  ext_en = 3'h4, ext_val = 3'h0, lvl, pin_o, pin_oe_n;
    logic [31:0] avs_readdata_o, seed = 32'd31, r;
    logic        avs_waitrequest_o, grant, tw_in, evt;
    logic [63:0] q[$];
    int          num_errors = 0, total_checks = 0;
    always #20 clk_i = ~clk_i;
    stsc_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .bus_master_disable_i(dis), .master_pending_i(pend), .master_want_i(want),
        .master_grant_o(grant), .device_reset_request_i(dreq), .reset_finished_i(dfin),
        .nv_signature_i(sig), .nv_gating_i(gat), .nv_two_wire_i(1'b0),
        .nv_pin2_value_i(1'b1), .nv_pin3_value_i(1'b0), .nv_pin2_dir_i(1'b1),
        .nv_pin3_dir_i(1'b0), .tw_clk_oe_n_i(tw_c), .tw_data_oe_n_i(tw_d),
        .tw_data_in_o(tw_in), .sw_pin_0_i(lvl[0]), .sw_pin_2_i(lvl[1]),
        .sw_pin_3_i(lvl[2]), .sw_pin_0_o(pin_o[0]), .sw_pin_0_oe_n_o(pin_oe_n[0]),
        .sw_pin_2_o(pin_o[1]), .sw_pin_2_oe_n_o(pin_oe_n[1]), .sw_pin_3_o(pin_o[2]),
        .sw_pin_3_oe_n_o(pin_oe_n[2]), .general_input_event_o(evt));
    stsc_pins u_pins (.dev_o_i(pin_o), .dev_oe_n_i(pin_oe_n), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .level_o(lvl));
    // Read monitor: oldest note is compared when the read is accepted
    always @(posedge clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            if (q.size() == 0) begin
                `CHK(1'b0, 1'b1)
            end else begin
                r = q.pop_front();
                `CHK(avs_readdata_o & r[63:32], r[31:0])
            end
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One bus cycle; held until waitrequest is sampled low
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        if (w) avs_write_i <= 1'b1;
        else avs_read_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            tally_and_finish();
        end
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        q.push_back({m, e});
        bus(a, 1'b0, 32'h0, 4'hF);
    endtask
    task automatic rst(input logic p);
        reset_i <= 1'b1;
        por_i <= p;
        cyc(4);
        reset_i <= 1'b0;
        por_i <= 1'b0;
        cyc(2);
    endtask
    // Toggle one outside pin and count detect pulses
    task automatic ev(input int idx, input int want_n);
        int n;
        n = 0;
        ext_val[idx] <= ~ext_val[idx];
        repeat (8) begin
            @(posedge clk_i);
            if (evt !== 1'b0) n++;
        end
        `CHK(n, want_n)
    endtask
    // Main sequence
    initial begin
        rst(1'b1);
        rd(8'h08, 32'hFFF8_0000, 32'h8028_0000);
        rd(8'h18, 32'h0000_0CCE, 32'h0000_0440);
        `CHK(pin_oe_n[1], 1'b0)
        `CHK(pin_o[1], 1'b1)
        rd(8'h40, 32'hFFFF_FFFF, 32'h0);
        $display("test reset done");
        dis <= 1'b1;
        want <= 1'b1;
        cyc(3);
        rd(8'h08, 32'h0008_0000, 32'h0008_0000);
        pend <= 1'b0;
        cyc(3);
        rd(8'h08, 32'h0008_0000, 32'h0);
        `CHK(grant, 1'b0)
        dis <= 1'b0;
        cyc(3);
        `CHK(grant, 1'b1)
        $display("test master done");
        dreq <= 1'b1;
        cyc(1);
        dreq <= 1'b0;
        cyc(2);
        rd(8'h08, 32'h0030_0000, 32'h0010_0000);
        bus(8'h08, 1'b1, 32'h0, 4'hF);
        rd(8'h08, 32'h0010_0000, 32'h0010_0000);
        bus(8'h08, 1'b1, 32'h0010_0000, 4'hF);
        rd(8'h08, 32'h0010_0000, 32'h0);
        dfin <= 1'b1;
        cyc(1);
        dfin <= 1'b0;
        cyc(2);
        rd(8'h08, 32'h0020_0000, 32'h0020_0000);
        $display("test flags done");
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            ext_val[2] <= seed[0];
            bus(8'h18, 1'b1, 32'h400 | {seed[1], 6'h0}, 4'h3);
            cyc(4);
            rd(8'h18, 32'hC0, {seed[0], seed[1], 6'h0});
            `CHK(pin_o[1], seed[1])
        end
        $display("test pins done");
        bus(8'h18, 1'b1, 32'h408, 4'h3);
        ev(2, 1);
        bus(8'h18, 1'b1, 32'h400, 4'h3);
        ev(2, 0);
        ext_en <= 3'h6;
        bus(8'h18, 1'b1, 32'h004, 4'h3);
        ev(1, 1);
        $display("test detect done");
        bus(8'h18, 1'b1, 32'h002, 4'h3);
        ext_en <= 3'h4;
        tw_c <= 1'b0;
        cyc(3);
        `CHK(pin_oe_n[0] | pin_o[0], 1'b0)
        tw_c <= 1'b1;
        ext_en <= 3'h6;
        ext_val <= 3'h0;
        cyc(4);
        `CHK(tw_in, 1'b0)
        tw_d <= 1'b0;
        cyc(3);
        `CHK(pin_oe_n[1] | pin_o[1], 1'b0)
        tw_d <= 1'b1;
        $display("test two-wire done");
        bus(8'h18, 1'b1, 32'h800, 4'h3);
        gat <= 1'b0;
        rst(1'b0);
        rd(8'h18, 32'h0C00, 32'h0800);
        rd(8'h08, 32'h8000_0000, 32'h0);
        sig <= 2'h0;
        gat <= 1'b1;
        rst(1'b1);
        rd(8'h08, 32'h8000_0000, 32'h0);
        rd(8'h18, 32'h0CC2, 32'h0);
        $display("test store done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
